/* src/dcff_top.sv */
// nine-bit fifo with flags, offset registers, apb status access and interrupt
// assumes writer, reader and apb master all run on mclk, reset synchronous high
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dcff_top #(
  parameter int WIDTH = dcff_pkg::WIDTH_DEFAULT,
  parameter int DEPTH = dcff_pkg::DEPTH_DEFAULT
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_enable_n,
  input wire logic write_enable2_or_load,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  output logic [WIDTH-1:0] data_out,
  output logic data_out_en_n,
  output logic full_flag_n,
  output logic empty_indicator_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic irq
);
  import dcff_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] level_reg;
  logic [CW-1:0] level_next;
  logic [CW-1:0] ae_off_reg;
  logic [CW-1:0] af_off_reg;
  logic second_en_mode_reg;
  logic load_sel_reg;
  logic full_n_reg;
  logic empty_n_reg;
  logic ae_n_reg;
  logic af_n_reg;
  logic [NUM_EV-1:0] irq_stat_reg;
  logic [NUM_EV-1:0] irq_mask_reg;
  logic [NUM_EV-1:0] ev_pulse;
  logic [31:0] prdata_reg;
  logic wr_req;
  logic rd_req;
  logic wr_do;
  logic rd_do;
  logic load_do;
  logic apb_wr;
  logic [WIDTH-1:0] mem_q;
  logic out_live_reg;

  // -------------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------------
  // second enable pin acts as enable or as load strobe, fixed at reset
  assign wr_req = !write_enable_n && (!second_en_mode_reg || write_enable2_or_load);
  assign load_do = !reset && !write_enable_n && second_en_mode_reg == 1'b0
                   && !write_enable2_or_load;
  assign rd_req = !read_enable_n;
  // requests against a full or empty memory are dropped outright
  assign wr_do = !reset && wr_req && !load_do && full_n_reg;
  assign rd_do = !reset && rd_req && empty_n_reg;

  // strap catch: sampled on every edge while reset is high, so clocks may run
  always_ff @(posedge mclk) begin
    if (reset) begin
      second_en_mode_reg <= write_enable2_or_load;
    end
  end

  // -------------------------------------------------------------------
  // pointers and fill level
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
    end else if (wr_do) begin
      wr_ptr_reg <= ptr_inc(wr_ptr_reg);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_ptr_reg <= '0;
    end else if (rd_do) begin
      rd_ptr_reg <= ptr_inc(rd_ptr_reg);
    end
  end

  // level moves only when exactly one side acts in a cycle
  always_comb begin
    level_next = level_reg;
    if (wr_do && !rd_do) begin
      level_next = level_reg + CW'(1);
    end else if (rd_do && !wr_do) begin
      level_next = level_reg - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

  // -------------------------------------------------------------------
  // flags, all registered from the next level so they move on the cause edge
  // -------------------------------------------------------------------
  // one clock means the skew window is always met: no extra lag is added
  always_ff @(posedge mclk) begin
    if (reset) begin
      full_n_reg <= 1'b1;
      empty_n_reg <= 1'b0;
      ae_n_reg <= 1'b0;
      af_n_reg <= 1'b1;
    end else begin
      full_n_reg <= level_next != DEPTH_C;
      empty_n_reg <= level_next != '0;
      ae_n_reg <= !(level_next < ae_off_reg);
      af_n_reg <= !(level_next > DEPTH_C - af_off_reg);
    end
  end
  assign full_flag_n = full_n_reg;
  assign empty_indicator_n = empty_n_reg;
  assign almost_empty_flag_n = ae_n_reg;
  assign almost_full_flag_n = af_n_reg;

  // -------------------------------------------------------------------
  // storage and output port
  // -------------------------------------------------------------------
  dcff_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .mclk(mclk),
    .wr_en(wr_do),
    .wr_addr(wr_ptr_reg),
    .wr_data(data_in),
    .rd_en(rd_do),
    .rd_addr(rd_ptr_reg),
    .rd_data(mem_q)
  );

  // the storage read register already holds the word taken at the read edge;
  // a second register here would show every word one accepted read late
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_live_reg <= 1'b0;
    end else if (rd_do) begin
      out_live_reg <= 1'b1;
    end
  end
  // pins read low after reset until the first accepted read
  assign data_out = out_live_reg ? mem_q : '0;

  // enable passes straight through; the pad releases the bus while it is high
  assign data_out_en_n = output_enable_n;

  // -------------------------------------------------------------------
  // offset registers: load strobe alternates almost-empty then almost-full
  // -------------------------------------------------------------------
  assign apb_wr = psel && penable && pwrite;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ae_off_reg <= CW'(OFFSET_RESET);
      af_off_reg <= CW'(OFFSET_RESET);
      load_sel_reg <= 1'b0;
    end else if (load_do) begin
      load_sel_reg <= !load_sel_reg;
      if (!load_sel_reg) begin
        ae_off_reg <= CW'(data_in);
      end else begin
        af_off_reg <= CW'(data_in);
      end
    end else if (apb_wr && paddr == AE_OFF_ADDR) begin
      ae_off_reg <= pwdata[CW-1:0];
    end else if (apb_wr && paddr == AF_OFF_ADDR) begin
      af_off_reg <= pwdata[CW-1:0];
    end
  end

  // -------------------------------------------------------------------
  // interrupt status and mask
  // -------------------------------------------------------------------
  always_comb begin
    ev_pulse = '0;
    ev_pulse[EV_FULL] = full_n_reg && level_next == DEPTH_C;
    ev_pulse[EV_EMPTY] = empty_n_reg && level_next == '0;
    ev_pulse[EV_AFULL] = af_n_reg && level_next > DEPTH_C - af_off_reg;
    ev_pulse[EV_AEMPTY] = ae_n_reg && level_next < ae_off_reg;
    ev_pulse[EV_OVER] = !reset && wr_req && !load_do && !full_n_reg;
    ev_pulse[EV_UNDER] = !reset && rd_req && !empty_n_reg;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_stat_reg <= '0;
    end else if (apb_wr && paddr == IRQ_STAT_ADDR) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[NUM_EV-1:0]) | ev_pulse;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev_pulse;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask_reg <= MASK_RESET;
    end else if (apb_wr && paddr == IRQ_MASK_ADDR) begin
      irq_mask_reg <= pwdata[NUM_EV-1:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // -------------------------------------------------------------------
  // apb slave: zero wait states, read data latched in the setup cycle
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_reg <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= '0;
      if (paddr == AE_OFF_ADDR) begin
        prdata_reg[CW-1:0] <= ae_off_reg;
      end else if (paddr == AF_OFF_ADDR) begin
        prdata_reg[CW-1:0] <= af_off_reg;
      end else if (paddr == STATUS_ADDR) begin
        prdata_reg[3:0] <= {ae_n_reg, af_n_reg, empty_n_reg, full_n_reg};
        prdata_reg[4] <= second_en_mode_reg;
        prdata_reg[ST_LEVEL_LSB +: CW] <= level_next;
      end else if (paddr == IRQ_STAT_ADDR) begin
        prdata_reg[NUM_EV-1:0] <= irq_stat_reg | ev_pulse;
      end else if (paddr == IRQ_MASK_ADDR) begin
        prdata_reg[NUM_EV-1:0] <= irq_mask_reg;
      end
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == AE_OFF_ADDR || paddr == AF_OFF_ADDR
                   || paddr == STATUS_ADDR || paddr == IRQ_STAT_ADDR || paddr == IRQ_MASK_ADDR);

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  sequence write_into_empty_s;
    !empty_n_reg && wr_do && !rd_do;
  endsequence
  sequence read_right_after_s;
    empty_n_reg && rd_req;
  endsequence

  full_release_a: assert property (@(posedge mclk) disable iff (reset)
    !full_n_reg && rd_do && !wr_do |=> full_n_reg)
    else $error("full flag did not release after a read");
  empty_clear_a: assert property (@(posedge mclk) disable iff (reset)
    write_into_empty_s |-> ##FLAG_LAG_CYCLES empty_n_reg)
    else $error("empty flag did not clear after a write");
  first_word_a: assert property (@(posedge mclk) disable iff (reset)
    write_into_empty_s ##1 read_right_after_s
    |=> data_out == $past(data_in, FIRST_READ_CYCLES))
    else $error("first word not readable right after empty cleared");
  reset_state_a: assert property (@(posedge mclk)
    reset |=> !empty_n_reg && !ae_n_reg && full_n_reg && af_n_reg
    && wr_ptr_reg == '0 && rd_ptr_reg == '0 && data_out == '0)
    else $error("reset state wrong");
  strap_mode_a: assert property (@(posedge mclk)
    reset ##1 !reset |-> second_en_mode_reg == $past(write_enable2_or_load))
    else $error("second enable strap not caught at reset");
  blocked_ops_a: assert property (@(posedge mclk) disable iff (reset)
    (wr_req && !full_n_reg && !rd_do) or (rd_req && !empty_n_reg && !wr_do)
    |=> $stable(level_reg) && $stable(data_out))
    else $error("blocked request changed state");
  almost_empty_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 ae_n_reg == !($past(level_next) < $past(ae_off_reg)))
    else $error("almost empty flag wrong");
  almost_full_a: assert property (@(posedge mclk) disable iff (reset)
    rd_do && !wr_do && !af_n_reg && level_reg == DEPTH_C - af_off_reg + CW'(1)
    |=> af_n_reg)
    else $error("almost full flag did not release at the threshold");
  load_route_a: assert property (@(posedge mclk) disable iff (reset)
    load_do && !load_sel_reg |=> ae_off_reg == CW'($past(data_in)) && !$past(wr_do))
    else $error("load strobe did not reach the offset register");
endmodule : dcff_top

/* src/dcff_pkg.sv */
// package of constants for the nine-bit first-in first-out memory block
// assumes one clock (mclk, 125 MHz) shared by writer, reader and the apb slave
package dcff_pkg;
  // -------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // -------------------------------------------------------------------
  localparam logic [7:0] AE_OFF_ADDR = 8'h00;
  localparam logic [7:0] AF_OFF_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int EV_FULL = 0;
  localparam int EV_EMPTY = 1;
  localparam int EV_AFULL = 2;
  localparam int EV_AEMPTY = 3;
  localparam int EV_OVER = 4;
  localparam int EV_UNDER = 5;
  localparam int NUM_EV = 6;
  localparam int ST_LEVEL_LSB = 8;
  localparam int OFFSET_RESET = 7;
  localparam logic [NUM_EV-1:0] MASK_RESET = 6'h00;
  localparam int DEPTH_DEFAULT = 64;
  localparam int WIDTH_DEFAULT = 9;
  // single-clock build: a flag change lands at most one edge after its cause
  localparam int FLAG_LAG_CYCLES = 1;
  localparam int FIRST_READ_CYCLES = 2;
endpackage : dcff_pkg

/* src/dcff_mem.sv */
// storage array of the fifo, one write port and one registered read port
// assumes the controller never writes and reads past the fill level
`timescale 1ns/1ps
module dcff_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  // write port, no reset on the array to keep it a plain ram
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port is registered; data holds between reads
  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end
  assign rd_data = rd_data_reg;

  read_hold_a: assert property (@(posedge mclk) !rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
endmodule : dcff_mem

/* tb/dcff_far.sv */
// writer and reader logic standing on the far side of the fifo stream pins
// assumes one shared clock; every request changes just after a rising edge
`timescale 1ns/1ps
module dcff_far (
  input wire logic mclk,
  output logic write_enable_n,
  output logic write_enable2_or_load,
  output logic [8:0] data_in,
  output logic read_enable_n
);
  logic pin_idle;
  // -------------------------------------------------------------------
  // idle levels
  // -------------------------------------------------------------------
  initial begin
    pin_idle = 1'b1;
    write_enable_n = 1'b1;
    write_enable2_or_load = 1'b1;
    data_in = 9'h000;
    read_enable_n = 1'b1;
  end
  // strap level for the dual-use pin, held through the reset pulse
  task automatic strap(input logic v);
    pin_idle <= v;
    write_enable2_or_load <= v;
  endtask : strap
  // one write cycle; the data line shows the inverse once released,
  // so a stale word can never pass for fresh data
  task automatic push(input logic [8:0] d, input logic en2);
    @(posedge mclk);
    write_enable_n <= 1'b0;
    write_enable2_or_load <= en2;
    data_in <= d;
    @(posedge mclk);
    write_enable_n <= 1'b1;
    write_enable2_or_load <= pin_idle;
    data_in <= ~d;
  endtask : push
  // write into the memory, then read on the very next edge
  task automatic push_pull(input logic [8:0] d);
    @(posedge mclk);
    write_enable_n <= 1'b0;
    write_enable2_or_load <= 1'b1;
    data_in <= d;
    @(posedge mclk);
    write_enable_n <= 1'b1;
    write_enable2_or_load <= pin_idle;
    data_in <= ~d;
    read_enable_n <= 1'b0;
    @(posedge mclk);
    read_enable_n <= 1'b1;
  endtask : push_pull
  // one read cycle
  task automatic pull;
    @(posedge mclk);
    read_enable_n <= 1'b0;
    @(posedge mclk);
    read_enable_n <= 1'b1;
  endtask : pull
endmodule : dcff_far

/* tb/dcff_top_tb.sv */
// self-checking bench for the fifo: flags, reset state, strap modes, apb and irq
// assumes the design answers apb with no wait states and flags land one edge late
`timescale 1ns/1ps
module dcff_top_tb;
  import dcff_pkg::*;
  localparam int DEPTH = 8;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic err;
  } dcff_row_t;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, output_enable_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic write_enable_n, write_enable2_or_load, read_enable_n, data_out_en_n, irq, err;
  logic full_flag_n, empty_indicator_n, almost_empty_flag_n, almost_full_flag_n;
  logic [8:0] data_in, data_out;
  int failures, checks, i;
  dcff_row_t rows [9];
  dcff_top #(.WIDTH(9), .DEPTH(DEPTH)) u_dut (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .write_enable_n(write_enable_n),
    .write_enable2_or_load(write_enable2_or_load), .data_in(data_in),
    .read_enable_n(read_enable_n), .output_enable_n(output_enable_n), .data_out(data_out),
    .data_out_en_n(data_out_en_n), .full_flag_n(full_flag_n),
    .empty_indicator_n(empty_indicator_n), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .irq(irq));
  dcff_far u_far (.mclk(mclk), .write_enable_n(write_enable_n),
    .write_enable2_or_load(write_enable2_or_load), .data_in(data_in),
    .read_enable_n(read_enable_n));
  // -------------------------------------------------------------------
  // clock and hang guard
  // -------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    close_out();
  end
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  // flags in the order full, empty, almost-full, almost-empty
  task automatic cmp_flags(input logic [3:0] exp);
    checks++;
    if ({full_flag_n, empty_indicator_n, almost_full_flag_n, almost_empty_flag_n} !== exp) begin
      failures++;
      $display("Error at %0t: flags wrong, expected %h", $time, exp);
    end
  endtask : cmp_flags
  // expected active-low flags for a fill level and offsets n and m
  function automatic logic [3:0] exp_flags(input int lvl, input int n, input int m);
    exp_flags = {lvl < DEPTH, lvl > 0, !(lvl > DEPTH - m), !(lvl < n)};
  endfunction : exp_flags
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  // reset for two edges with the strap level on the dual-use pin
  task automatic do_reset(input logic v);
    @(posedge mclk);
    reset <= 1'b1;
    u_far.strap(v);
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
  endtask : do_reset
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    output_enable_n = 1'b0;
    failures = 0;
    checks = 0;
    rows = '{'{1'b0, AE_OFF_ADDR, 32'h0, 32'h7, 1'b0}, '{1'b0, STATUS_ADDR, 32'h0, 32'h15, 1'b0},
      '{1'b0, IRQ_MASK_ADDR, 32'h0, 32'h0, 1'b0}, '{1'b1, AE_OFF_ADDR, 32'h2, 32'h0, 1'b0},
      '{1'b1, AF_OFF_ADDR, 32'h3, 32'h0, 1'b0}, '{1'b0, AE_OFF_ADDR, 32'h0, 32'h2, 1'b0},
      '{1'b0, AF_OFF_ADDR, 32'h0, 32'h3, 1'b0}, '{1'b1, 8'h14, 32'h9, 32'h0, 1'b1},
      '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1}};
    do_reset(1'b1);
    cmp_flags(exp_flags(0, 7, 7));
    cmp(data_out, 32'h0);
    cmp(data_out_en_n, 32'h0);
    @(posedge mclk);
    output_enable_n <= 1'b1;
    #1;
    cmp(data_out_en_n, 32'h1);
    $display("test reset done");
    // register table rows
    for (i = 0; i < 9; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) cmp(rd, rows[i].exp);
      cmp({31'h0, err}, {31'h0, rows[i].err});
    end
    $display("test registers done");
    // first word through an empty memory
    u_far.push(9'h1A5, 1'b1);
    #1;
    cmp_flags(exp_flags(1, 2, 3));
    u_far.pull();
    #1;
    cmp(data_out, 32'h1A5);
    cmp_flags(exp_flags(0, 2, 3));
    // second enable low in enable mode blocks the write
    u_far.push(9'h055, 1'b0);
    #1;
    cmp_flags(exp_flags(0, 2, 3));
    $display("test first word done");
    // fill to full, then one refused write
    for (i = 0; i < DEPTH; i++) begin
      u_far.push(9'h100 + 9'(i), 1'b1);
      #1;
      cmp_flags(exp_flags(i + 1, 2, 3));
    end
    u_far.push(9'h0AA, 1'b1);
    #1;
    cmp_flags(exp_flags(DEPTH, 2, 3));
    cmp(irq, 32'h0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1 << EV_OVER);
    cmp(irq, 32'h1);
    apb(1'b1, IRQ_STAT_ADDR, 32'h1 << EV_OVER);
    cmp(irq, 32'h0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    $display("test fill done");
    // drain in order, then one refused read
    for (i = 0; i < DEPTH; i++) begin
      u_far.pull();
      #1;
      cmp(data_out, 32'h100 + i);
      cmp_flags(exp_flags(DEPTH - 1 - i, 2, 3));
    end
    u_far.pull();
    #1;
    cmp(data_out, 32'h100 + DEPTH - 1);
    cmp_flags(exp_flags(0, 2, 3));
    $display("test drain done");
    // write into the empty memory and read it on the next edge
    u_far.push_pull(9'h0C3);
    #1;
    cmp(data_out, 32'h0C3);
    cmp_flags(exp_flags(0, 2, 3));
    $display("test back to back done");
    // second reset with strap low: pin becomes the offset load strobe
    do_reset(1'b0);
    cmp_flags(exp_flags(0, 7, 7));
    u_far.push(9'h005, 1'b0);
    u_far.push(9'h006, 1'b0);
    #1;
    cmp_flags(exp_flags(0, 5, 6));
    apb(1'b0, AE_OFF_ADDR, 32'h0);
    cmp(rd, 32'h5);
    apb(1'b0, AF_OFF_ADDR, 32'h0);
    cmp(rd, 32'h6);
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp(rd, 32'h05);
    $display("test load mode done");
    close_out();
  end
endmodule : dcff_top_tb
